// ---- keyboard_pin_pkg.sv ----
package keyboard_pin_pkg;

  // pin count and bus widths
  localparam int KEY_PIN_COUNT = 5;
  localparam int AXI_ADDR_W = 8;

  // register byte addresses
  localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFF_PIN_ENABLE = 8'h04;
  localparam logic [7:0] OFF_PIN_POLARITY = 8'h08;
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h0C;
  localparam logic [7:0] OFF_EVENT_MASK = 8'h10;

  // key_status_control field positions
  localparam int SC_SENS_BIT = 0;
  localparam int SC_MASK_BIT = 1;
  localparam int SC_ACK_BIT = 2;
  localparam int SC_PEND_BIT = 3;

  // event status / mask field positions
  localparam int EVT_REQUEST_BIT = 0;

  // reset values
  localparam logic RST_SENSITIVITY = 1'b0;
  localparam logic RST_REQUEST_MASK = 1'b0;
  localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
  localparam logic [7:0] RST_PIN_POLARITY = 8'h00;
  localparam logic RST_EVENT_MASK = 1'b0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic sensitivity_select;
    logic request_mask;
    logic [7:0] pin_enable;
    logic [7:0] pin_polarity;
    logic latch;
    logic ack_seen;
    logic prev_any;
    logic evt_status;
    logic evt_mask;
  } kbd_state_t;

endpackage

// ---- keyboard_pin_interrupt.sv ----
// Summary of operation
// - Every key pin feeds one shared interrupt request and has its own enable and polarity bits.
// - An enabled pin gets a pullup when active-low and a pulldown when active-high.
// - The pending flag reads 1 while a request is latched and 0 otherwise.
// - Writing 1 to the acknowledge bit clears the latched request in edge-only mode and acknowledges it in edge-and-level mode, and the bit always reads 0.
// - With the request mask at 1 the latched request does not reach the CPU; at 0 it does.
// - The sensitivity bit picks edge-and-level triggering at 1 and edge-only triggering at 0.
// - Each of the five enable bits lets its pin latch requests at 1 and excludes it at 0.
// - A polarity bit of 1 means rising edge or high level, 0 means falling edge or low level.
// - Reset clears the whole polarity register, so pins default to falling or low detection.
// - In edge-only mode a new edge latches nothing while another enabled pin is still asserted.
// - In edge-and-level mode the request clears only after both deassertion of all pins and an ack.
// - Reset clears the latched request and the sensitivity bit even with an input asserted.
// - The pending flag shows the latch whatever the mask holds, so software can poll it.
module keyboard_pin_interrupt
  import keyboard_pin_pkg::*;
#(
  parameter int PIN_COUNT = KEY_PIN_COUNT
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // axi4-lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [AXI_ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  // axi4-lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [AXI_ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  // axi4-lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // key pins and pull devices
  input wire logic [PIN_COUNT-1:0] i_key_wake_input,
  output logic [PIN_COUNT-1:0] o_pullup_en,
  output logic [PIN_COUNT-1:0] o_pulldown_en,
  // cpu side
  input wire logic i_vector_fetch,
  output logic o_cpu_request,
  output logic o_irq
);

  localparam logic [7:0] PIN_MASK = 8'((1 << PIN_COUNT) - 1);

  kbd_state_t st;
  kbd_state_t next_st;

  logic [PIN_COUNT-1:0] pin_asserted;
  logic any_asserted;
  logic key_edge;
  logic ack_pulse;
  logic wr_fire;
  logic [31:0] rd_value;
  logic rd_hit;

  // per-pin detection and pull selection
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      // pin is asserted at its own polarity, gated by its own enable
      assign pin_asserted[gi] = st.pin_enable[gi] &
                                (st.pin_polarity[gi] ? i_key_wake_input[gi] : ~i_key_wake_input[gi]);
      assign o_pullup_en[gi] = st.pin_enable[gi] & ~st.pin_polarity[gi];
      assign o_pulldown_en[gi] = st.pin_enable[gi] & st.pin_polarity[gi];
    end
  endgenerate

  // edges are taken on the OR of all pins, so a held pin hides others
  assign any_asserted = |pin_asserted;
  assign key_edge = any_asserted & ~st.prev_any;

  assign wr_fire = st.aw_have & st.w_have & ~st.bvalid;
  assign ack_pulse = i_vector_fetch |
                     (wr_fire & st.w_lane0 & (st.aw_addr == OFF_STATUS_CONTROL) & st.w_data[SC_ACK_BIT]);

  // read mux
  always_comb begin
    rd_value = 32'h0;
    rd_hit = 1'b1;
    unique case (i_araddr)
      OFF_STATUS_CONTROL: begin
        rd_value[SC_PEND_BIT] = st.latch;
        rd_value[SC_MASK_BIT] = st.request_mask;
        rd_value[SC_SENS_BIT] = st.sensitivity_select;
      end
      OFF_PIN_ENABLE: begin
        rd_value[7:0] = st.pin_enable;
      end
      OFF_PIN_POLARITY: begin
        rd_value[7:0] = st.pin_polarity;
      end
      OFF_EVENT_STATUS: begin
        rd_value[EVT_REQUEST_BIT] = st.evt_status;
      end
      OFF_EVENT_MASK: begin
        rd_value[EVT_REQUEST_BIT] = st.evt_mask;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    // write address and data are taken independently, in either order
    if (i_awvalid && o_awready) begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_st.w_have = 1'b1;
      next_st.w_data = i_wdata[7:0];
      next_st.w_lane0 = i_wstrb[0];
    end
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      // only byte lane 0 carries register bits; upper lanes are ignored
      unique case (st.aw_addr)
        OFF_STATUS_CONTROL: begin
          if (st.w_lane0) begin
            next_st.request_mask = st.w_data[SC_MASK_BIT];
            next_st.sensitivity_select = st.w_data[SC_SENS_BIT];
          end
        end
        OFF_PIN_ENABLE: begin
          if (st.w_lane0) begin
            next_st.pin_enable = st.w_data & PIN_MASK;
          end
        end
        OFF_PIN_POLARITY: begin
          if (st.w_lane0) begin
            next_st.pin_polarity = st.w_data & PIN_MASK;
          end
        end
        OFF_EVENT_STATUS: begin
          if (st.w_lane0 && st.w_data[EVT_REQUEST_BIT]) begin
            next_st.evt_status = 1'b0;
          end
        end
        OFF_EVENT_MASK: begin
          if (st.w_lane0) begin
            next_st.evt_mask = st.w_data[EVT_REQUEST_BIT];
          end
        end
        default: begin
          next_st.bresp = RESP_SLVERR;
        end
      endcase
    end

    // read channel: one read in flight, data registered
    if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_value;
      next_st.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // request latch
    next_st.prev_any = any_asserted;
    if (st.sensitivity_select) begin
      // ack is remembered until every enabled pin has let go
      if (st.latch) begin
        if ((ack_pulse || st.ack_seen) && !any_asserted && !key_edge) begin
          next_st.latch = 1'b0;
          next_st.ack_seen = 1'b0;
        end else if (ack_pulse) begin
          next_st.ack_seen = 1'b1;
        end
      end else begin
        next_st.latch = any_asserted;
        next_st.ack_seen = 1'b0;
      end
    end else begin
      // a new edge in the ack cycle wins over the clear
      next_st.latch = key_edge | (st.latch & ~ack_pulse);
      next_st.ack_seen = 1'b0;
    end

    // sticky event on each new request; set wins over write-one-to-clear
    if (next_st.latch && !st.latch) begin
      next_st.evt_status = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.bresp <= RESP_OKAY;
      st.rresp <= RESP_OKAY;
      st.sensitivity_select <= RST_SENSITIVITY;
      st.request_mask <= RST_REQUEST_MASK;
      st.pin_enable <= RST_PIN_ENABLE;
      st.pin_polarity <= RST_PIN_POLARITY;
      st.latch <= 1'b0;
      st.evt_mask <= RST_EVENT_MASK;
    end else begin
      st <= next_st;
    end
  end

  assign o_awready = ~st.aw_have & ~st.bvalid;
  assign o_wready = ~st.w_have & ~st.bvalid;
  assign o_bvalid = st.bvalid;
  assign o_bresp = st.bresp;
  assign o_arready = ~st.rvalid;
  assign o_rvalid = st.rvalid;
  assign o_rdata = st.rdata;
  assign o_rresp = st.rresp;
  // the mask blocks the cpu path only; the pending flag is untouched
  assign o_cpu_request = st.latch & ~st.request_mask;
  assign o_irq = st.evt_status & st.evt_mask;

  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // request latch in edge-only mode
  chk_edge_sets_latch: assert property (key_edge |=> st.latch)
    else $error("edge did not latch a request");

  chk_held_pin_blocks: assert property (
    !st.sensitivity_select && !st.latch && st.prev_any && any_asserted && !ack_pulse |=> !st.latch)
    else $error("edge latched while another pin held");

  chk_edge_only_idle: assert property (
    !st.sensitivity_select && !st.latch && !key_edge |=> !st.latch)
    else $error("edge mode latched without an edge");

  chk_edge_ack_clears: assert property (
    !st.sensitivity_select && st.latch && ack_pulse && !key_edge |=> !st.latch)
    else $error("ack did not clear edge request");

  chk_edge_holds: assert property (
    !st.sensitivity_select && st.latch && !ack_pulse |=> st.latch)
    else $error("edge request lost without ack");

  chk_vector_ack: assert property (
    !st.sensitivity_select && st.latch && i_vector_fetch && !key_edge |=> !st.latch)
    else $error("vector fetch did not acknowledge");

  // request latch in edge-and-level mode
  chk_level_sets: assert property (
    st.sensitivity_select && any_asserted |=> st.latch)
    else $error("asserted pin did not latch in level mode");

  chk_level_holds: assert property (
    st.sensitivity_select && st.latch && any_asserted |=> st.latch)
    else $error("level request cleared while pin asserted");

  chk_level_no_ack: assert property (
    st.sensitivity_select && st.latch && !ack_pulse && !st.ack_seen |=> st.latch)
    else $error("level request cleared without ack");

  chk_level_both_clear: assert property (
    st.sensitivity_select && st.latch && ack_pulse ##1 !any_asserted [*2] |=> !st.latch)
    else $error("level request not cleared after ack and release");

  // pin qualification and pull devices
  chk_disabled_pins: assert property (
    st.pin_enable[PIN_COUNT-1:0] == '0 |-> !any_asserted)
    else $error("disabled pins raised a request");

  chk_high_active: assert property (
    |(st.pin_enable[PIN_COUNT-1:0] & st.pin_polarity[PIN_COUNT-1:0] & i_key_wake_input) |-> any_asserted)
    else $error("high level on active-high pin not seen");

  chk_low_active: assert property (
    |(st.pin_enable[PIN_COUNT-1:0] & ~st.pin_polarity[PIN_COUNT-1:0] & ~i_key_wake_input) |-> any_asserted)
    else $error("low level on active-low pin not seen");

  chk_pull_select: assert property (
    ((o_pullup_en & o_pulldown_en) == '0)
    && ((o_pullup_en | o_pulldown_en) == st.pin_enable[PIN_COUNT-1:0]))
    else $error("pull devices inconsistent with enables");

  // register view, mask and cpu path
  chk_ack_reads_zero: assert property (
    i_arvalid && o_arready && i_araddr == OFF_STATUS_CONTROL
    |=> o_rdata[SC_ACK_BIT] == 1'b0 && o_rdata[7:4] == 4'h0
        && o_rdata[SC_PEND_BIT] == $past(st.latch))
    else $error("status read shows wrong pending or nonzero ack");

  chk_mask_gates_cpu: assert property (
    $rose(st.latch) && !st.request_mask |-> o_cpu_request)
    else $error("unmasked request not forwarded");

  chk_mask_blocks_cpu: assert property (st.request_mask |-> !o_cpu_request)
    else $error("masked request reached cpu");

  chk_cpu_needs_latch: assert property (!st.latch |-> !o_cpu_request)
    else $error("cpu request without a latched request");

  // bus answers, event flag and reset defaults
  chk_write_answer: assert property (
    st.aw_have && st.w_have && !st.bvalid |=> o_bvalid)
    else $error("write response missing");

  chk_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data missing");

  chk_event_sticky: assert property (
    st.evt_status && !wr_fire |=> st.evt_status)
    else $error("event status dropped without a clear");

  chk_event_sets: assert property ($rose(st.latch) |-> st.evt_status)
    else $error("new request did not set event status");

  chk_reset_defaults: assert property (
    $fell(i_rst) |-> st.pin_polarity == 8'h00 && !st.latch && !st.sensitivity_select)
    else $error("reset values wrong");

  cov_edge_request: cover property (key_edge ##1 o_cpu_request);
  cov_level_ack_first: cover property (st.sensitivity_select && st.latch && ack_pulse && any_asserted);
  cov_vector_ack: cover property (i_vector_fetch && st.latch ##1 !st.latch);
  cov_irq_out: cover property ($rose(o_irq));

endmodule

// ---- key_switch_model.sv ----
module key_switch_model (
  // clock
  input wire logic i_core_clk,
  // key contacts and pull devices
  input wire logic [4:0] i_press,
  input wire logic [4:0] i_pullup_en,
  input wire logic [4:0] i_pulldown_en,
  // pin levels
  output logic [4:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;
  // a floating pin must not look steady, so it toggles each cycle
  always_ff @(posedge i_core_clk) begin
    flip <= ~flip;
  end
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      if (i_press[k]) begin
        o_pin[k] = i_pulldown_en[k];
      end else if (i_pullup_en[k] | i_pulldown_en[k]) begin
        o_pin[k] = i_pullup_en[k];
      end else begin
        o_pin[k] = flip ^ k[0];
      end
    end
  end
endmodule

// ---- keyboard_pin_interrupt_tb.sv ----
module keyboard_pin_interrupt_tb
  import keyboard_pin_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, vf = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] resp;
  logic [4:0] press = 0, pins, pu, pd;
  logic [3:0] strb = 4'hF;
  logic awr, wr_rdy, bv, arr, rv, cpu_req, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rd_w;
  int err_total = 0, n_checks = 0;
  always #5 clk = ~clk;
  keyboard_pin_interrupt dut (.i_core_clk(clk), .i_rst(rst), .i_awvalid(awv), .o_awready(awr),
    .i_awaddr(awaddr), .i_awprot(3'h0), .i_wvalid(wv), .o_wready(wr_rdy), .i_wdata(wdata),
    .i_wstrb(strb), .o_bvalid(bv), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arv),
    .o_arready(arr), .i_araddr(araddr), .i_arprot(3'h0), .o_rvalid(rv), .i_rready(rready),
    .o_rdata(rd_w), .o_rresp(rresp), .i_key_wake_input(pins), .o_pullup_en(pu),
    .o_pulldown_en(pd), .i_vector_fetch(vf), .o_cpu_request(cpu_req), .o_irq(irq));
  key_switch_model keys (.i_core_clk(clk), .i_press(press), .i_pullup_en(pu), .i_pulldown_en(pd),
    .o_pin(pins));
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // handshakes are judged at the falling edge, where readies have settled
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    while (!tb) begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wr_rdy;
      tb = bv & bready;
      resp = bresp;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end
    bready <= 0;
    // idle edge so a following call does not re-drive bready in this step
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a);
    logic ta, tr;
    tr = 0;
    araddr <= a;
    arv <= 1;
    rready <= 1;
    while (!tr) begin
      @(negedge clk);
      ta = arv & arr;
      tr = rv & rready;
      rdata = rd_w;
      resp = rresp;
      @(posedge clk);
      if (ta) arv <= 0;
    end
    rready <= 0;
    @(posedge clk);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), rdata, e);
  endtask
  task key(input logic [4:0] v);
    press <= v;
    repeat (3) @(posedge clk);
  endtask
  task sig(input string nm, input logic s, input logic e);
    #1;
    chk(nm, {31'h0, s}, {31'h0, e});
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rc(OFF_STATUS_CONTROL, 32'h0);
    rc(OFF_PIN_POLARITY, 32'h0);
    rd(8'h14);
    chk("read resp", resp, RESP_SLVERR);
    wr(8'h14, 32'h1);
    chk("write resp", resp, RESP_SLVERR);
    wr(OFF_PIN_POLARITY, 32'h03);
    wr(OFF_PIN_ENABLE, 32'h0F);
    chk("pullups", pu, 5'h0C);
    chk("pulldowns", pd, 5'h03);
    strb <= 4'hE;
    wr(OFF_PIN_ENABLE, 32'h00);
    strb <= 4'hF;
    rc(OFF_PIN_ENABLE, 32'h0F);
    // enabling can fake an edge, so acknowledge first
    wr(OFF_STATUS_CONTROL, 32'h04);
    rc(OFF_STATUS_CONTROL, 32'h0);
    key(5'h04);
    rc(OFF_STATUS_CONTROL, 32'h08);
    sig("cpu request", cpu_req, 1);
    wr(OFF_EVENT_MASK, 32'h1);
    sig("irq", irq, 1);
    wr(OFF_EVENT_STATUS, 32'h1);
    sig("irq", irq, 0);
    wr(OFF_STATUS_CONTROL, 32'h04);
    key(5'h0C);
    rc(OFF_STATUS_CONTROL, 32'h0);
    key(5'h00);
    key(5'h01);
    rc(OFF_STATUS_CONTROL, 32'h08);
    @(posedge clk);
    vf <= 1;
    @(posedge clk);
    vf <= 0;
    key(5'h00);
    rc(OFF_STATUS_CONTROL, 32'h0);
    wr(OFF_STATUS_CONTROL, 32'hF2);
    rc(OFF_STATUS_CONTROL, 32'h02);
    key(5'h02);
    rc(OFF_STATUS_CONTROL, 32'h0A);
    sig("cpu request", cpu_req, 0);
    wr(OFF_STATUS_CONTROL, 32'hF6);
    rc(OFF_STATUS_CONTROL, 32'h02);
    key(5'h00);
    wr(OFF_STATUS_CONTROL, 32'h01);
    key(5'h02);
    rc(OFF_STATUS_CONTROL, 32'h09);
    wr(OFF_STATUS_CONTROL, 32'h05);
    rc(OFF_STATUS_CONTROL, 32'h09);
    key(5'h00);
    rc(OFF_STATUS_CONTROL, 32'h01);
    key(5'h08);
    key(5'h00);
    rc(OFF_STATUS_CONTROL, 32'h09);
    wr(OFF_STATUS_CONTROL, 32'h05);
    rc(OFF_STATUS_CONTROL, 32'h01);
    key(5'h08);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rc(OFF_STATUS_CONTROL, 32'h0);
    rc(OFF_PIN_POLARITY, 32'h0);
    test_done;
  end
endmodule
